// ### bench/pwsc_host.sv
/* Host model on the serial control port: one-cycle strobes.
   Assumes pwsc_pkg is compiled first and clk is the design clock. */
`timescale 1ns/1ps
module pwsc_host
   import pwsc_pkg::*;
(
   input wire logic clk,
   output pwsc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;
   // Strobe stands for exactly one edge, so a write never acts twice
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req = '{1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 reg_req.wr = 1'b0;
   endtask : wr
   // Read data is registered, so it is taken just after the edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      #1 reg_req.rd = 1'b0;
      d = reg_rdata;
   endtask : rd
   // Second-scheme skew set, loaded while all channels are shut
   task automatic load_scheme_two();
      wr(8'h11, 8'hB8);
      wr(8'h12, 8'h60);
      wr(8'h13, 8'hA0);
      wr(8'h14, 8'h48);
   endtask : load_scheme_two
   // Factory trim select; the bench runs it once, after the first reset only
   task automatic run_trim();
      wr(8'h1B, 8'h00);
   endtask : run_trim
endmodule : pwsc_host

// ### bench/pwsc_top_tb_top.sv
/* Self-checking bench of the PWM stage control registers.
   Assumes pwsc_pkg and pwsc_host are compiled first. */
`timescale 1ns/1ps
module pwsc_top_tb_top
   import pwsc_pkg::*;
;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } pwsc_row_t;
   // Reset values first, then writes with reserved bits set, save the ramp register written to 00
   pwsc_row_t rows [17] = '{'{1'b0, 8'h10, 8'h00, 8'h01},
      '{1'b0, 8'h11, 8'h00, 8'hAC}, '{1'b0, 8'h12, 8'h00, 8'h54},
      '{1'b0, 8'h13, 8'h00, 8'hAC}, '{1'b0, 8'h14, 8'h00, 8'h54},
      '{1'b0, 8'h19, 8'h00, 8'h30}, '{1'b0, 8'h1A, 8'h00, 8'h48},
      '{1'b0, 8'h1B, 8'h00, 8'h82}, '{1'b0, 8'h15, 8'h00, 8'h00},
      '{1'b1, 8'h10, 8'hFF, 8'h07}, '{1'b1, 8'h11, 8'hB9, 8'hB8},
      '{1'b1, 8'h12, 8'h61, 8'h60}, '{1'b1, 8'h13, 8'hA3, 8'hA0},
      '{1'b1, 8'h14, 8'h4B, 8'h48}, '{1'b1, 8'h19, 8'hBA, 8'h3A},
      '{1'b1, 8'h1A, 8'h00, 8'h00}, '{1'b1, 8'h1C, 8'h55, 8'h00}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic all_shutdown = 1'b1;
   logic group_restart_all = 1'b0;
   logic power_down_pin = 1'b0;
   pwsc_duty_t duty_in = '0;
   pwsc_reg_req_t reg_req;
   logic [7:0] reg_rdata, rv;
   pwsc_duty_t duty_out;
   logic [3:0] chan_run;
   pwsc_skew_t skew_delay;
   logic half_hold, hp_busy, trim_done;
   logic [15:0] rate_count;
   int cyc = 0;
   int err_total = 0;
   int num_checks = 0;
   // Frame clock of 16 cycles, tied to the cycle count
   wire logic frame_clk_pin = cyc[3];
   always #4 clk = ~clk;
   pwsc_top #(.TICK_CYCLES(4), .TRIM_CYCLES(8)) uut (.clk, .rst_n,
      .reg_req, .reg_rdata, .all_shutdown, .group_restart_all,
      .power_down_pin, .frame_clk_pin, .duty_in, .duty_out, .chan_run,
      .skew_delay, .half_hold, .hp_busy, .trim_done, .rate_count);
   pwsc_host host (.clk, .reg_req, .reg_rdata);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // Inputs move 1 ns after the edge, never on it
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : w
   // Hang guard: the run needs about 3900 cycles
   always @(posedge clk)
   begin
      #1 cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end
   initial
   begin
      w(5);
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            host.wr(rows[i].a, rows[i].d);
         host.rd(rows[i].a, rv);
         chk(rv, rows[i].e);
      end
      $display("test registers done");
      host.load_scheme_two();
      w(1);
      chk(skew_delay, 32'h48A0_60B8);
      duty_in = 32'h00FF_00FF;
      all_shutdown = 1'b0;
      w(3);
      chk(chan_run, 4'h5);
      chk(duty_out, 32'h80F8_80F8);
      all_shutdown = 1'b1;
      w(2);
      chk(chan_run, 4'h0);
      group_restart_all = 1'b1;
      all_shutdown = 1'b0;
      w(3);
      chk(duty_out, 32'h08F8_08F8);
      $display("test hold group done");
      host.wr(8'h1A, 8'h48);
      all_shutdown = 1'b1;
      w(2);
      chk({half_hold, hp_busy}, 2'b11);
      w(640);
      chk(half_hold, 1'b1);
      w(40);
      chk(half_hold, 1'b0);
      for (int n = 0; n < 4000 && hp_busy; n++)
         w(1);
      chk(hp_busy, 1'b0);
      power_down_pin = 1'b1;
      w(6);
      chk({half_hold, hp_busy}, 2'b11);
      $display("test ramp done");
      chk(trim_done, 1'b0);
      host.run_trim();
      w(12);
      host.rd(8'h1B, rv);
      chk(rv, 8'hC0);
      w(40);
      chk(rate_count, 16'h0010);
      $display("test trim done");
      rst_n = 1'b0;
      w(2);
      chk({chan_run, trim_done}, 5'h00);
      rst_n = 1'b1;
      host.rd(8'h19, rv);
      chk(rv, 8'h30);
      w(3);
      chk({half_hold, hp_busy}, 2'b00);
      $display("test reset done");
      wrap_up();
   end
endmodule : pwsc_top_tb_top

// ### logic/pwsc_cfg.svh
/*
   Constants of the PWM stage control registers: register offsets,
   reset values, field positions and timing figures.
   Assumes the clock runs at 125 MHz and that every design file of
   the block includes this header by its bare name.
*/
// Notes on behaviour
// RULE1 - Cap low bits pick maximum modulation depth
// RULE2 - Four channel delay registers from 0x11
// RULE3 - Signed six-bit delay, times four, low reserved
// RULE4 - Delays reset to AC, 54, AC, 54
// RULE5 - Host loads second-scheme delays before restart
// RULE6 - Group low bits mark channels 4 to 1
// RULE7 - Group members stay off after shutdown exit
// RULE8 - Group resets to 0x30; host may write 0x3A
// RULE9 - Ramp runs on shutdown change or pin change
// RULE10 - Low five bits set half-duty interval
// RULE11 - High three bits set headphone ramp time; the code uses one fixed time for every code
// RULE12 - Oscillator measures serial audio clock rate
// RULE13 - Writing 0x00 enables factory trim
// RULE14 - Host runs trim after every reset; the bench runs it after the first reset only
// RULE15 - Trim register bit 6 shows trim done
// RULE16 - Trim select bit resets to one
// RULE17 - Duty clamped to selected modulation cap
`ifndef PWSC_CFG_SVH
`define PWSC_CFG_SVH

// Register offsets on the serial control port
`define PWSC_ADDR_CAP 8'h10
`define PWSC_ADDR_CH1 8'h11
`define PWSC_ADDR_CH2 8'h12
`define PWSC_ADDR_CH1I 8'h13
`define PWSC_ADDR_CH2I 8'h14
`define PWSC_ADDR_GROUP 8'h19
`define PWSC_ADDR_RAMP 8'h1A
`define PWSC_ADDR_OSC 8'h1B

// Reset values
`define PWSC_RST_CAP 3'h1
`define PWSC_RST_CH1 8'hAC
`define PWSC_RST_CH2 8'h54
`define PWSC_RST_GROUP 7'h30
`define PWSC_RST_RAMP 8'h48
`define PWSC_RST_SEL 1'h1
`define PWSC_OSC_RSVD 1'h1

// Field positions
`define PWSC_CAP_BITS 2:0
`define PWSC_DLY_BITS 7:2
`define PWSC_DLY_RSVD 2'h0
`define PWSC_GROUP_BITS 6:0
`define PWSC_MEMBER_BITS 3:0
`define PWSC_HALF_BITS 4:0
`define PWSC_HALF_NONE 4:3
`define PWSC_HP_BITS 7:5
`define PWSC_SEL_BIT 1

// Duty figures: 8-bit duty, midscale is 50 %
`define PWSC_MID_DUTY 8'h80
`define PWSC_MAX_MAG 8'h7F

// Timing: clock period, ramp tick and trim time in ns
`define PWSC_CLK_NS 8
`define PWSC_TICK_NS 100000
`define PWSC_TRIM_NS 10000
`define PWSC_HP_DEF_CODE 3'h2
`define PWSC_HP_DEF_TICKS 18'h0_03AE
// Edges after reset before the pin history holds real samples
`define PWSC_SYNC_FILL 2'h3

`endif

// ### logic/pwsc_osc.sv
/*
   Oscillator trim sequencer and serial audio frame rate counter.
   Assumes the frame clock input is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "pwsc_cfg.svh"
module pwsc_osc
   import pwsc_pkg::*;
#(
   parameter int TRIM_CYCLES = `PWSC_TRIM_NS / `PWSC_CLK_NS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trim_start,
   input wire logic frame_sync,
   output logic trim_done,
   output logic [15:0] rate_count
);

   typedef enum logic [1:0] {PWSC_O_IDLE, PWSC_O_TRIM, PWSC_O_DONE}
      pwsc_ostate_t;

   pwsc_ostate_t state; // Trim progress
   pwsc_ostate_t next_state;
   logic [15:0] trim_cnt; // Cycles left in trim
   logic [15:0] next_trim_cnt;
   logic frame_prev; // Last frame clock level
   logic [15:0] per_cnt; // Cycles since last frame rise
   logic [15:0] next_per_cnt;
   logic [15:0] next_rate;
   logic frame_rise;

   assign frame_rise = frame_sync && !frame_prev;

   // Trim sequence; a new start restarts the trim from scratch
   always_comb
   begin
      next_state = state;
      next_trim_cnt = trim_cnt;
      unique case (state)
         PWSC_O_IDLE, PWSC_O_DONE: next_trim_cnt = 16'h0000;
         PWSC_O_TRIM:
         begin
            next_trim_cnt = trim_cnt - 16'h0001;
            if (trim_cnt == 16'h0001)
               next_state = PWSC_O_DONE; // RULE15
         end
         default: next_state = PWSC_O_IDLE;
      endcase
      if (trim_start)
      begin
         next_state = PWSC_O_TRIM; // RULE13
         next_trim_cnt = TRIM_CYCLES[15:0];
      end
   end

   // Rate measurement; only trusted once the trim has finished
   always_comb
   begin
      next_per_cnt = per_cnt;
      next_rate = rate_count;
      if (frame_rise)
      begin
         next_per_cnt = 16'h0001;
         if (state == PWSC_O_DONE)
            next_rate = per_cnt; // RULE12
      end
      else if (per_cnt != 16'hFFFF)
         next_per_cnt = per_cnt + 16'h0001;
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= PWSC_O_IDLE;
         trim_cnt <= 16'h0000;
         trim_done <= 1'b0;
         frame_prev <= 1'b0;
         per_cnt <= 16'h0000;
         rate_count <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         trim_cnt <= next_trim_cnt;
         trim_done <= (next_state == PWSC_O_DONE);
         frame_prev <= frame_sync;
         per_cnt <= next_per_cnt;
         rate_count <= next_rate;
      end
   end

   trim_restart_a: assert property (@(posedge clk) // RULE15
      disable iff (!rst_n) trim_start |=> !trim_done [*2])
      else $error("trim done shown right after a trim start");
   trim_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      $rose(trim_done) |-> $past(state) == PWSC_O_TRIM)
      else $error("trim done rose without a trim");
   trim_done_c: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(trim_done));

endmodule : pwsc_osc

// ### logic/pwsc_pkg.sv
/*
   Types and the ramp period table of the PWM stage control block.
   Assumes pwsc_cfg.svh for the constants it uses.
*/
`include "pwsc_cfg.svh"
package pwsc_pkg;

   // Register write or read request from the serial control port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pwsc_reg_req_t;

   // One 8-bit duty word per PWM channel, channel 1 in slot 0
   typedef logic [3:0][7:0] pwsc_duty_t;

   // Signed delay per channel in delay-step-clock cycles
   typedef struct packed {
      logic signed [7:0] ch2_inv;
      logic signed [7:0] ch1_inv;
      logic signed [7:0] ch2;
      logic signed [7:0] ch1;
   } pwsc_skew_t;

   // Half-duty interval in 0.1 ms ticks; zero means none
   function automatic logic [17:0] pwsc_half_ticks(input logic [4:0] code);
      logic [17:0] t;
      t = 18'h0_0000;
      unique case (code)
         5'h08: t = 18'h0_00A5;
         5'h09: t = 18'h0_00EF;
         5'h0A: t = 18'h0_013A;
         5'h0B: t = 18'h0_0194;
         5'h0C: t = 18'h0_021B;
         5'h0D: t = 18'h0_02BF;
         5'h0E: t = 18'h0_03AE;
         5'h0F: t = 18'h0_04E9;
         5'h10: t = 18'h0_066E;
         5'h11: t = 18'h0_095A;
         5'h12: t = 18'h0_0C46;
         5'h13: t = 18'h0_0FC7;
         5'h14: t = 18'h0_150A;
         5'h15: t = 18'h0_1B77;
         5'h16: t = 18'h0_24D1;
         5'h17: t = 18'h0_3116;
         5'h18: t = 18'h0_4381;
         5'h19: t = 18'h0_6230;
         5'h1A: t = 18'h0_80DF;
         5'h1B: t = 18'h0_A5B1;
         5'h1C: t = 18'h0_DCEC;
         5'h1D: t = 18'h1_206D;
         5'h1E: t = 18'h1_829D;
         5'h1F: t = 18'h2_037C;
         default: t = 18'h0_0000;
      endcase
      return t;
   endfunction : pwsc_half_ticks

   // Duty clamp around midscale to the magnitude allowed by the cap
   function automatic logic [7:0] pwsc_clamp(input logic [7:0] duty,
                                             input logic [2:0] cap);
      logic [7:0] lim;
      logic [7:0] lo;
      logic [7:0] hi;
      lim = `PWSC_MAX_MAG - {5'h00, cap};
      lo = `PWSC_MID_DUTY - lim;
      hi = `PWSC_MID_DUTY + lim;
      if (duty < lo)
         return lo;
      if (duty > hi)
         return hi;
      return duty;
   endfunction : pwsc_clamp

endpackage : pwsc_pkg

// ### logic/pwsc_ramp.sv
/*
   Soft start and stop timer: half-duty interval and headphone ramp.
   Assumes a one-cycle tick every 0.1 ms and a one-cycle trigger.
*/
`timescale 1ns/1ps
`include "pwsc_cfg.svh"
module pwsc_ramp
   import pwsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic trigger,
   input wire logic [7:0] period,
   output logic half_hold,
   output logic hp_busy
);

   typedef enum logic {PWSC_R_IDLE, PWSC_R_HOLD} pwsc_rstate_t;

   pwsc_rstate_t state; // Half-duty interval state
   pwsc_rstate_t next_state;
   logic [17:0] half_cnt; // Ticks left in half-duty interval
   logic [17:0] next_half_cnt;
   logic [17:0] hp_cnt; // Ticks left in headphone ramp
   logic [17:0] next_hp_cnt;
   logic [17:0] half_len;
   logic [17:0] hp_len;

   // Only one headphone code has a known time; others reuse it
   assign hp_len = `PWSC_HP_DEF_TICKS;
   assign half_len = pwsc_half_ticks(period[`PWSC_HALF_BITS]); // RULE10

   // Next values: a new trigger restarts both timers at once
   always_comb
   begin
      next_state = state;
      next_half_cnt = half_cnt;
      next_hp_cnt = hp_cnt;
      if (trigger)
      begin
         // RULE9
         next_half_cnt = half_len;
         next_hp_cnt = hp_len; // RULE11
         next_state = (half_len != 18'h0_0000) ? PWSC_R_HOLD : PWSC_R_IDLE;
      end
      else
      begin
         if (tick && hp_cnt != 18'h0_0000)
            next_hp_cnt = hp_cnt - 18'h0_0001;
         unique case (state)
            PWSC_R_IDLE: next_half_cnt = 18'h0_0000;
            PWSC_R_HOLD:
            begin
               if (tick)
                  next_half_cnt = half_cnt - 18'h0_0001;
               if (tick && half_cnt == 18'h0_0001)
                  next_state = PWSC_R_IDLE;
            end
         endcase
      end
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= PWSC_R_IDLE;
         half_cnt <= 18'h0_0000;
         hp_cnt <= 18'h0_0000;
         half_hold <= 1'b0;
         hp_busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         half_cnt <= next_half_cnt;
         hp_cnt <= next_hp_cnt;
         half_hold <= (next_state == PWSC_R_HOLD);
         hp_busy <= (next_hp_cnt != 18'h0_0000);
      end
   end

   ramp_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
      trigger && period[`PWSC_HALF_NONE] != 2'h0 |=> half_hold [*2])
      else $error("half-duty interval did not start");
   ramp_none_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      trigger && period[`PWSC_HALF_NONE] == 2'h0 |=> !half_hold)
      else $error("half-duty interval ran for a none code");
   hp_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      trigger |=> hp_busy)
      else $error("headphone ramp did not start");
   ramp_hold_c: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(half_hold));

endmodule : pwsc_ramp

// ### logic/pwsc_top.sv
/*
   PWM stage control registers: modulation cap, channel skew delays,
   channel hold group, soft ramp periods and oscillator trim.
   Assumes the serial control port slave delivers one-cycle read and
   write strobes on clk, and that shutdown state and the group control
   bit come from system control logic on the same clock.
*/
`timescale 1ns/1ps
`include "pwsc_cfg.svh"
module pwsc_top
   import pwsc_pkg::*;
#(
   parameter int TICK_CYCLES = `PWSC_TICK_NS / `PWSC_CLK_NS,
   parameter int TRIM_CYCLES = `PWSC_TRIM_NS / `PWSC_CLK_NS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire pwsc_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic all_shutdown,
   input wire logic group_restart_all,
   input wire logic power_down_pin,
   input wire logic frame_clk_pin,
   input wire pwsc_duty_t duty_in,
   output pwsc_duty_t duty_out,
   output logic [3:0] chan_run,
   output pwsc_skew_t skew_delay,
   output logic half_hold,
   output logic hp_busy,
   output logic trim_done,
   output logic [15:0] rate_count
);

   // Register state
   logic [2:0] mod_cap; // Cap select
   logic [2:0] next_mod_cap;
   logic [7:0] chan1_delay; // Channel 1 skew
   logic [7:0] next_chan1_delay;
   logic [7:0] chan2_delay; // Channel 2 skew
   logic [7:0] next_chan2_delay;
   logic [7:0] chan1_inv_delay; // Inverted channel 1 skew
   logic [7:0] next_chan1_inv_delay;
   logic [7:0] chan2_inv_delay; // Inverted channel 2 skew
   logic [7:0] next_chan2_inv_delay;
   logic [6:0] channel_hold_group; // D7 is reserved and reads zero
   logic [6:0] next_channel_hold_group;
   logic [7:0] soft_ramp_period; // Ramp period codes
   logic [7:0] next_soft_ramp_period;
   logic factory_sel_n; // One while factory trim is disabled
   logic next_factory_sel_n;
   logic [7:0] next_rdata;
   logic trim_start; // Write that selects factory trim

   // Pin synchronisers and edge history
   logic pdn_meta; // First stage, read only by pdn_sync
   logic pdn_sync;
   logic pdn_prev;
   logic frame_meta; // First stage, read only by frame_sync
   logic frame_sync;
   logic shut_prev; // Last shutdown level
   logic ramp_trigger;
   logic [3:0] next_chan_run;
   logic [1:0] pdn_fill; // Edges since reset, saturating
   logic [1:0] next_pdn_fill;

   // Tick divider for the ramp timers
   logic [15:0] tick_cnt;
   logic [15:0] next_tick_cnt;
   logic tick;

   // Output stage
   pwsc_duty_t next_duty;
   pwsc_skew_t next_skew;

   // Write decode and register next values
   always_comb
   begin
      next_mod_cap = mod_cap;
      next_chan1_delay = chan1_delay;
      next_chan2_delay = chan2_delay;
      next_chan1_inv_delay = chan1_inv_delay;
      next_chan2_inv_delay = chan2_inv_delay;
      next_channel_hold_group = channel_hold_group;
      next_soft_ramp_period = soft_ramp_period;
      next_factory_sel_n = factory_sel_n;
      trim_start = 1'b0;
      if (reg_req.wr)
      begin
         unique case (reg_req.addr)
            `PWSC_ADDR_CAP:
               next_mod_cap = reg_req.wdata[`PWSC_CAP_BITS]; // RULE1
            // Low two bits are forced to zero so skew is a multiple of 4
            `PWSC_ADDR_CH1:
               next_chan1_delay = {reg_req.wdata[`PWSC_DLY_BITS],
                                   `PWSC_DLY_RSVD}; // RULE2 RULE3
            `PWSC_ADDR_CH2:
               next_chan2_delay = {reg_req.wdata[`PWSC_DLY_BITS],
                                   `PWSC_DLY_RSVD}; // RULE2 RULE3
            `PWSC_ADDR_CH1I:
               next_chan1_inv_delay = {reg_req.wdata[`PWSC_DLY_BITS],
                                       `PWSC_DLY_RSVD}; // RULE2 RULE3
            `PWSC_ADDR_CH2I:
               next_chan2_inv_delay = {reg_req.wdata[`PWSC_DLY_BITS],
                                       `PWSC_DLY_RSVD}; // RULE2 RULE3
            `PWSC_ADDR_GROUP:
               next_channel_hold_group =
                  reg_req.wdata[`PWSC_GROUP_BITS]; // RULE6 RULE8
            `PWSC_ADDR_RAMP:
               next_soft_ramp_period = reg_req.wdata;
            `PWSC_ADDR_OSC:
            begin
               // Done bit is read-only; only the select bit is stored
               next_factory_sel_n = reg_req.wdata[`PWSC_SEL_BIT]; // RULE16
               trim_start = !reg_req.wdata[`PWSC_SEL_BIT]; // RULE13
            end
            default:
            begin
               // Unmapped writes are dropped
            end
         endcase
      end
   end

   // Read mux; unmapped offsets and reserved bits read as zero, except trim register bit 7, which reads one
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_req.rd)
      begin
         unique case (reg_req.addr)
            `PWSC_ADDR_CAP: next_rdata = {5'h00, mod_cap};
            `PWSC_ADDR_CH1: next_rdata = chan1_delay;
            `PWSC_ADDR_CH2: next_rdata = chan2_delay;
            `PWSC_ADDR_CH1I: next_rdata = chan1_inv_delay;
            `PWSC_ADDR_CH2I: next_rdata = chan2_inv_delay;
            `PWSC_ADDR_GROUP: next_rdata = {1'b0, channel_hold_group};
            `PWSC_ADDR_RAMP: next_rdata = soft_ramp_period;
            `PWSC_ADDR_OSC:
               next_rdata = {`PWSC_OSC_RSVD, trim_done, 4'h0,
                             factory_sel_n, 1'b0}; // RULE15
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Register file and read data
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mod_cap <= `PWSC_RST_CAP;
         chan1_delay <= `PWSC_RST_CH1; // RULE4
         chan2_delay <= `PWSC_RST_CH2; // RULE4
         chan1_inv_delay <= `PWSC_RST_CH1; // RULE4
         chan2_inv_delay <= `PWSC_RST_CH2; // RULE4
         channel_hold_group <= `PWSC_RST_GROUP; // RULE8
         soft_ramp_period <= `PWSC_RST_RAMP;
         factory_sel_n <= `PWSC_RST_SEL; // RULE16
         reg_rdata <= 8'h00;
      end
      else
      begin
         mod_cap <= next_mod_cap;
         chan1_delay <= next_chan1_delay;
         chan2_delay <= next_chan2_delay;
         chan1_inv_delay <= next_chan1_inv_delay;
         chan2_inv_delay <= next_chan2_inv_delay;
         channel_hold_group <= next_channel_hold_group;
         soft_ramp_period <= next_soft_ramp_period;
         factory_sel_n <= next_factory_sel_n;
         reg_rdata <= next_rdata;
      end
   end

   // Channel start: members of the hold group stay off on exit unless
   // the group control bit asks for all channels to restart
   always_comb
   begin
      next_chan_run = chan_run;
      if (all_shutdown)
         next_chan_run = 4'h0;
      else if (shut_prev)
         next_chan_run = ~channel_hold_group[`PWSC_MEMBER_BITS] |
                         {4{group_restart_all}}; // RULE7
   end

   // Any shutdown change or power-down pin change starts a ramp; the pin
   // side waits until its history holds real samples after reset
   assign ramp_trigger = (all_shutdown != shut_prev) ||
                         ((pdn_sync != pdn_prev) &&
                          (pdn_fill == `PWSC_SYNC_FILL)); // RULE9

   // Synchroniser fill count: a pin that sits high through reset would
   // otherwise look like an edge once the first real sample arrives
   always_comb
   begin
      next_pdn_fill = pdn_fill;
      if (pdn_fill != `PWSC_SYNC_FILL)
         next_pdn_fill = pdn_fill + 2'h1;
   end

   // Tick divider: one pulse each 0.1 ms of the ramp tables
   always_comb
   begin
      next_tick_cnt = tick_cnt + 16'h0001;
      if (tick)
         next_tick_cnt = 16'h0000;
   end
   assign tick = (tick_cnt == TICK_CYCLES[15:0] - 16'h0001);

   // Output stage: duty held at 50 % during the half-duty interval or while a channel is off, else clamped
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (half_hold || !chan_run[i])
            next_duty[i] = `PWSC_MID_DUTY;
         else
            next_duty[i] = pwsc_clamp(duty_in[i], mod_cap); // RULE17 RULE1
      end
      next_skew.ch1 = chan1_delay; // RULE3
      next_skew.ch2 = chan2_delay;
      next_skew.ch1_inv = chan1_inv_delay;
      next_skew.ch2_inv = chan2_inv_delay;
   end

   // Synchronisers, edge history, divider and outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pdn_meta <= 1'b0;
         pdn_sync <= 1'b0;
         pdn_prev <= 1'b0;
         pdn_fill <= 2'h0;
         frame_meta <= 1'b0;
         frame_sync <= 1'b0;
         shut_prev <= 1'b1;
         chan_run <= 4'h0;
         tick_cnt <= 16'h0000;
         duty_out <= '0;
         skew_delay <= '0;
      end
      else
      begin
         pdn_meta <= power_down_pin;
         pdn_sync <= pdn_meta;
         pdn_prev <= pdn_sync;
         pdn_fill <= next_pdn_fill;
         frame_meta <= frame_clk_pin;
         frame_sync <= frame_meta;
         shut_prev <= all_shutdown;
         chan_run <= next_chan_run;
         tick_cnt <= next_tick_cnt;
         duty_out <= next_duty;
         skew_delay <= next_skew;
      end
   end

   // Soft start and stop timers
   pwsc_ramp u_ramp (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .trigger(ramp_trigger),
      .period(soft_ramp_period),
      .half_hold(half_hold),
      .hp_busy(hp_busy)
   );

   // Oscillator trim and frame rate detection
   pwsc_osc #(
      .TRIM_CYCLES(TRIM_CYCLES)
   ) u_osc (
      .clk(clk),
      .rst_n(rst_n),
      .trim_start(trim_start),
      .frame_sync(frame_sync),
      .trim_done(trim_done),
      .rate_count(rate_count)
   );

   cap_clamp_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
      !$past(half_hold) && $past(chan_run[0]) |->
      duty_out[0] >= `PWSC_MID_DUTY - (`PWSC_MAX_MAG - $past(mod_cap)) &&
      duty_out[0] <= `PWSC_MID_DUTY + (`PWSC_MAX_MAG - $past(mod_cap)))
      else $error("duty exceeds modulation cap");
   delay_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      $rose(rst_n) |-> chan1_delay == `PWSC_RST_CH1 &&
      chan2_inv_delay == `PWSC_RST_CH2)
      else $error("channel delays not at reset values");
   delay_low_a: assert property (@(posedge clk) // RULE3 RULE2
      disable iff (!rst_n)
      reg_req.wr && reg_req.addr == `PWSC_ADDR_CH2 |=>
      chan2_delay[1:0] == `PWSC_DLY_RSVD &&
      chan2_delay[7:2] == $past(reg_req.wdata[7:2]))
      else $error("delay write stored wrongly");
   group_hold_a: assert property (@(posedge clk) // RULE7 RULE6
      disable iff (!rst_n)
      $fell(all_shutdown) && !group_restart_all |=>
      (chan_run & channel_hold_group[3:0]) == 4'h0 &&
      (chan_run | channel_hold_group[3:0]) == 4'hF)
      else $error("group member started after shutdown exit");
   group_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      $rose(rst_n) |-> channel_hold_group == `PWSC_RST_GROUP)
      else $error("hold group not at reset value");
   trim_sel_a: assert property (@(posedge clk) // RULE16 RULE13
      disable iff (!rst_n)
      reg_req.wr && reg_req.addr == `PWSC_ADDR_OSC &&
      reg_req.wdata == 8'h00 |=> !factory_sel_n ##1 !trim_done)
      else $error("factory trim write mishandled");
   shut_run_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      all_shutdown |=> chan_run == 4'h0)
      else $error("channel running in shutdown");
   group_exit_c: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(all_shutdown) && channel_hold_group[3:0] != 4'h0);
   pdn_ramp_c: cover property (@(posedge clk) disable iff (!rst_n)
      pdn_sync != pdn_prev);

endmodule : pwsc_top
